// File: rtl/csa_pkg.sv
/*
 * package for the core storage attribute and addressing block.
 * holds register numbers, field positions, sizes and carrier structs.
 * assumes one clock domain and a decoded micro-operation from the core.
 */
package csa_pkg;

    localparam int unsigned GR_COUNT   = 32;
    localparam int unsigned GR_AW      = 5;
    localparam int unsigned XLEN       = 32;
    localparam int unsigned REGION_MSB = 31;
    localparam int unsigned REGION_LSB = 27;

    // special register numbers, 10 bits as encoded
    localparam logic [9:0] SPR_XER   = 10'h001;
    localparam logic [9:0] SPR_LINK  = 10'h008;
    localparam logic [9:0] SPR_COUNT = 10'h009;
    localparam logic [9:0] SPR_GS4   = 10'h104;
    localparam logic [9:0] SPR_GS7   = 10'h107;
    localparam logic [9:0] SPR_TBLO  = 10'h11C;
    localparam logic [9:0] SPR_TBUP  = 10'h11D;
    localparam logic [9:0] SPR_WTHR  = 10'h3BA;
    localparam logic [9:0] SPR_GUARD = 10'h3B9;
    localparam logic [9:0] SPR_LEND  = 10'h3BB;
    localparam logic [9:0] SPR_UDEF  = 10'h3BC;
    localparam logic [9:0] SPR_ICACH = 10'h3FB;
    localparam logic [9:0] SPR_DCACH = 10'h3FA;
    localparam logic [9:0] TBR_LO    = 10'h10C;
    localparam logic [9:0] TBR_UP    = 10'h10D;

    // machine state fields
    localparam int unsigned MS_PR = 14;
    localparam int unsigned MS_IR = 5;
    localparam int unsigned MS_DR = 4;

    localparam logic [31:0] MS_RESET    = 32'h0000_0000;
    localparam logic [31:0] REGION_RST  = 32'h0000_0000;
    localparam logic [31:0] COND_RESET  = 32'h0000_0000;

    typedef enum logic [1:0] {
        CSA_SZ_BYTE,
        CSA_SZ_HALF,
        CSA_SZ_WORD
    } csa_size_t;

    typedef enum logic [3:0] {
        CSA_OP_NONE,
        CSA_OP_MEM,
        CSA_OP_MTSPR,
        CSA_OP_MFSPR,
        CSA_OP_MFTB,
        CSA_OP_MTMSR,
        CSA_OP_MFMSR,
        CSA_OP_MTDCR,
        CSA_OP_MFDCR,
        CSA_OP_CMP,
        CSA_OP_CRLOG,
        CSA_OP_ALU,
        CSA_OP_MOVE
    } csa_op_t;

    typedef enum logic [3:0] {
        CSA_CL_AND, CSA_CL_OR, CSA_CL_XOR, CSA_CL_NAND,
        CSA_CL_NOR, CSA_CL_EQV, CSA_CL_ANDC, CSA_CL_ORC
    } csa_crlog_t;

    // one operation from the decoder
    typedef struct packed {
        csa_op_t      op;
        logic         idx_mode;  // indexed rather than displacement
        logic         update;    // write address back to base
        logic         base_zero; // implied base of zero
        logic [4:0]   ra;
        logic [4:0]   rb;
        logic [4:0]   rt;
        logic [15:0]  disp;
        logic [9:0]   sprn;
        csa_size_t    size;
        logic         sign_ext;
        logic         instr_side;
        logic [2:0]   crf;       // condition field selector
        logic [4:0]   bt;
        logic [4:0]   ba;
        logic [4:0]   bb;
        csa_crlog_t   crlog;
        logic         rc;        // update first condition field; marks a store on memory ops
    } csa_req_t;

    // attributes presented with each access
    typedef struct packed {
        logic       write_through;
        logic       cache_inhibit;
        logic       guarded;
        logic       user_def;
        logic       little_end;
    } csa_attr_t;

    typedef struct packed {
        logic [31:0] addr;
        csa_size_t   size;
        logic        sign_ext;
        logic        is_store;
        logic        instr_side;
        csa_attr_t   attr;
    } csa_access_t;

    // attributes from a translation entry
    typedef struct packed {
        logic       w;
        logic       i;
        logic       m;
        logic       g;
        logic       u0;
        logic       e;
    } csa_tlb_attr_t;

endpackage

// File: rtl/csa_core.sv
/*
 * programming-model logic: general registers, machine state, condition
 * register, region attribute registers, address forming, privilege checks.
 * assumes a decoder hands one operation per cycle and the memory side
 * takes the access descriptor and returns loaded data the next cycles.
 */
`timescale 1ns/1ps

module csa_core
    import csa_pkg::*;
(
    input  wire logic          clk_sys_i,
    input  wire logic          sys_rst_i,
    input  wire logic          req_valid_i,
    input  wire csa_req_t      req_i,
    input  wire logic [31:0]   load_data_i,
    input  wire logic          load_valid_i,
    input  wire logic [63:0]   time_base_i,
    input  wire csa_tlb_attr_t tlb_attr_i,
    input  wire logic [31:0]   alu_result_i,
    input  wire logic [31:0]   spr_rdata_i,
    output logic               acc_valid_o,
    output csa_access_t        acc_o,
    output logic [31:0]        store_data_o,
    output logic               priv_fault_o,
    output logic               spr_we_o,
    output logic [9:0]         spr_num_o,
    output logic [31:0]        spr_wdata_o,
    output logic               dcr_valid_o,
    output logic [31:0]        msr_o,
    output logic [31:0]        cond_o
);

    logic [31:0] gr_q [GR_COUNT];
    logic [31:0] msr_q;
    logic [31:0] cond_q;
    logic [31:0] wthr_q, dcach_q, icach_q, guard_q, lend_q, udef_q;
    logic [4:0]  ld_rt_q;
    csa_size_t   ld_size_q;
    logic        ld_sext_q;
    logic        ld_le_q;
    logic        ld_store_q;

    logic        user_mode;
    logic        spr_ok;
    logic        priv_bad;
    logic        go;
    logic [31:0] base_val, offs_val, ea;
    logic [4:0]  region;
    logic        xlate;
    csa_attr_t   attr;
    logic [31:0] ld_word;
    logic [31:0] cmp_res;
    logic [3:0]  cmp_fld;
    logic        ca, cb, cr_res;

    assign user_mode = msr_q[MS_PR];

    always_comb begin
        spr_ok = 1'b0;
        unique case (req_i.op)
            CSA_OP_MTSPR: spr_ok = (req_i.sprn == SPR_XER)
                                 || (req_i.sprn == SPR_LINK)
                                 || (req_i.sprn == SPR_COUNT);
            CSA_OP_MFSPR: spr_ok = (req_i.sprn == SPR_XER)
                                 || (req_i.sprn == SPR_LINK)
                                 || (req_i.sprn == SPR_COUNT)
                                 || (req_i.sprn >= SPR_GS4
                                     && req_i.sprn <= SPR_GS7);
            CSA_OP_MFTB:  spr_ok = 1'b1;
            default:      spr_ok = 1'b1;
        endcase
    end

    always_comb begin
        priv_bad = 1'b0;
        if (user_mode) begin
            unique case (req_i.op)
                CSA_OP_MTSPR, CSA_OP_MFSPR: priv_bad = !spr_ok;
                CSA_OP_MTMSR, CSA_OP_MTDCR, CSA_OP_MFDCR: priv_bad = 1'b1;
                default: priv_bad = 1'b0;
            endcase
        end
    end

    // special path time base read refused, write-only
    assign go = req_valid_i && !priv_bad
        && !(req_i.op == CSA_OP_MFSPR
             && (req_i.sprn == SPR_TBLO || req_i.sprn == SPR_TBUP));

    always_comb begin
        base_val = req_i.base_zero ? 32'h0000_0000 : gr_q[req_i.ra];
        offs_val = req_i.idx_mode ? gr_q[req_i.rb]
                                  : {{16{req_i.disp[15]}}, req_i.disp};
        ea = base_val + offs_val;
    end

    // top five address bits pick region
    assign region = ea[REGION_MSB:REGION_LSB];
    assign xlate  = req_i.instr_side ? msr_q[MS_IR] : msr_q[MS_DR];

    always_comb begin
        if (xlate) begin
            attr.write_through = tlb_attr_i.w;
            attr.cache_inhibit = tlb_attr_i.i;
            attr.guarded       = tlb_attr_i.g;
            attr.user_def      = tlb_attr_i.u0;
            attr.little_end    = tlb_attr_i.e;
        end else begin
            attr.write_through = wthr_q[region];
            attr.cache_inhibit = req_i.instr_side ? !icach_q[region]
                                                  : !dcach_q[region];
            attr.guarded       = guard_q[region];
            attr.user_def      = udef_q[region];
            attr.little_end    = lend_q[region];
        end
    end

    // address is lowest byte of operand
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            acc_valid_o  <= 1'b0;
            acc_o        <= '0;
            store_data_o <= 32'h0000_0000;
        end else begin
            acc_valid_o     <= go && req_i.op == CSA_OP_MEM;
            acc_o.addr      <= ea;
            acc_o.size      <= req_i.size;
            acc_o.sign_ext  <= req_i.sign_ext;
            acc_o.is_store  <= req_i.rc;
            acc_o.instr_side<= req_i.instr_side;
            acc_o.attr      <= attr;
            store_data_o    <= gr_q[req_i.rt];
        end
    end

    // pending load destination
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ld_rt_q    <= 5'h00;
            ld_size_q  <= CSA_SZ_WORD;
            ld_sext_q  <= 1'b0;
            ld_le_q    <= 1'b0;
            ld_store_q <= 1'b1;
        end else if (go && req_i.op == CSA_OP_MEM) begin
            ld_rt_q    <= req_i.rt;
            ld_size_q  <= req_i.size;
            ld_sext_q  <= req_i.sign_ext;
            ld_le_q    <= attr.little_end;
            ld_store_q <= req_i.rc;
        end
    end

    // byte order and extension of loaded data
    always_comb begin
        ld_word = 32'h0000_0000;
        unique case (ld_size_q)
            CSA_SZ_BYTE: ld_word = {{24{ld_sext_q && load_data_i[7]}},
                                    load_data_i[7:0]};
            CSA_SZ_HALF: begin
                if (ld_le_q)
                    ld_word = {{16{ld_sext_q && load_data_i[15]}},
                               load_data_i[15:0]};
                else
                    ld_word = {{16{ld_sext_q && load_data_i[7]}},
                               load_data_i[7:0], load_data_i[15:8]};
            end
            default: ld_word = ld_le_q ? load_data_i
                             : {load_data_i[7:0], load_data_i[15:8],
                                load_data_i[23:16], load_data_i[31:24]};
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            for (int k = 0; k < GR_COUNT; k++) gr_q[k] <= 32'h0000_0000;
        end else begin
            if (load_valid_i && !ld_store_q) gr_q[ld_rt_q] <= ld_word;
            if (go) begin
                unique case (req_i.op)
                    CSA_OP_MEM:   if (req_i.update && !req_i.base_zero)
                                      gr_q[req_i.ra] <= ea;
                    CSA_OP_MFSPR: gr_q[req_i.rt] <= spr_rdata_i;
                    CSA_OP_MFTB:  gr_q[req_i.rt] <= (req_i.sprn == TBR_UP)
                                      ? time_base_i[63:32]
                                      : time_base_i[31:0];
                    CSA_OP_MFMSR: gr_q[req_i.rt] <= msr_q;
                    CSA_OP_ALU:   gr_q[req_i.rt] <= alu_result_i;
                    CSA_OP_MOVE:  gr_q[req_i.rt] <= gr_q[req_i.ra];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) msr_q <= MS_RESET;
        else if (go && req_i.op == CSA_OP_MTMSR) msr_q <= gr_q[req_i.rt];
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wthr_q <= REGION_RST; dcach_q <= REGION_RST;
            icach_q <= REGION_RST; guard_q <= REGION_RST;
            lend_q <= REGION_RST; udef_q <= REGION_RST;
        end else if (go && req_i.op == CSA_OP_MTSPR) begin
            unique case (req_i.sprn)
                SPR_WTHR:  wthr_q  <= gr_q[req_i.rt];
                SPR_DCACH: dcach_q <= gr_q[req_i.rt];
                SPR_ICACH: icach_q <= gr_q[req_i.rt];
                SPR_GUARD: guard_q <= gr_q[req_i.rt];
                SPR_LEND:  lend_q  <= gr_q[req_i.rt];
                SPR_UDEF:  udef_q  <= gr_q[req_i.rt];
                default: ;
            endcase
        end
    end

    assign cmp_res = gr_q[req_i.ra] - gr_q[req_i.rb];
    always_comb begin
        if (req_i.sign_ext)
            cmp_fld = {$signed(gr_q[req_i.ra]) < $signed(gr_q[req_i.rb]),
                       $signed(gr_q[req_i.ra]) > $signed(gr_q[req_i.rb]),
                       cmp_res == 32'h0000_0000, 1'b0};
        else
            cmp_fld = {gr_q[req_i.ra] < gr_q[req_i.rb],
                       gr_q[req_i.ra] > gr_q[req_i.rb],
                       cmp_res == 32'h0000_0000, 1'b0};
        ca = cond_q[5'd31 - req_i.ba];
        cb = cond_q[5'd31 - req_i.bb];
        unique case (req_i.crlog)
            CSA_CL_AND:  cr_res = ca & cb;
            CSA_CL_OR:   cr_res = ca | cb;
            CSA_CL_XOR:  cr_res = ca ^ cb;
            CSA_CL_NAND: cr_res = !(ca & cb);
            CSA_CL_NOR:  cr_res = !(ca | cb);
            CSA_CL_EQV:  cr_res = !(ca ^ cb);
            CSA_CL_ANDC: cr_res = ca & !cb;
            default:     cr_res = ca | !cb;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) cond_q <= COND_RESET;
        else if (go) begin
            unique case (req_i.op)
                CSA_OP_CMP:   cond_q[5'd31 - {req_i.crf, 2'b00} -: 4]
                                  <= cmp_fld;
                CSA_OP_CRLOG: cond_q[5'd31 - req_i.bt] <= cr_res;
                // first field from result sign and zero
                CSA_OP_ALU:   if (req_i.rc)
                                  cond_q[31:28] <= {alu_result_i[31],
                                      !alu_result_i[31]
                                      && alu_result_i != 32'h0000_0000,
                                      alu_result_i == 32'h0000_0000, 1'b0};
                default: ;
            endcase
        end
    end

    // special and device bus strobes
    assign priv_fault_o = req_valid_i && priv_bad;
    assign spr_we_o     = go && req_i.op == CSA_OP_MTSPR;
    assign spr_num_o    = req_i.sprn;
    assign spr_wdata_o  = gr_q[req_i.rt];
    assign dcr_valid_o  = go && (req_i.op == CSA_OP_MTDCR
                                 || req_i.op == CSA_OP_MFDCR);
    assign msr_o        = msr_q;
    assign cond_o       = cond_q;

endmodule

// File: verif/csa_core_monitor.sv
/*
 * checker for csa_core: privilege refusals, device control moves,
 * access descriptor timing and machine state protection.
 * assumes it is bound to csa_core and sees only its ports.
 */
`timescale 1ns/1ps

module csa_core_monitor
    import csa_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        sys_rst_i,
    input wire logic        req_valid_i,
    input wire csa_req_t    req_i,
    input wire logic        acc_valid_o,
    input wire logic        priv_fault_o,
    input wire logic        spr_we_o,
    input wire logic [9:0]  spr_num_o,
    input wire logic        dcr_valid_o,
    input wire logic [31:0] msr_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    // user state and the open special registers
    wire logic usr    = msr_o[MS_PR];
    wire logic op_mts = req_valid_i && req_i.op == CSA_OP_MTSPR;
    wire logic open_w = req_i.sprn == SPR_XER || req_i.sprn == SPR_LINK
                        || req_i.sprn == SPR_COUNT;

    property p_mem_acc;
        req_valid_i && req_i.op == CSA_OP_MEM |=> acc_valid_o;
    endproperty
    a_mem_acc: assert property (p_mem_acc)
        else $error("memory request gave no access");

    property p_acc_cause;
        acc_valid_o |-> $past(req_valid_i) && $past(req_i.op) == CSA_OP_MEM;
    endproperty
    a_acc_cause: assert property (p_acc_cause)
        else $error("access without memory request");

    property p_usr_spr;
        op_mts && usr && !open_w |-> priv_fault_o && !spr_we_o;
    endproperty
    a_usr_spr: assert property (p_usr_spr)
        else $error("user write of closed special register");

    property p_usr_cnt;
        op_mts && usr && req_i.sprn == SPR_COUNT
            |-> !priv_fault_o && spr_we_o && spr_num_o == SPR_COUNT;
    endproperty
    a_usr_cnt: assert property (p_usr_cnt)
        else $error("user write of count refused");

    property p_tb_path;
        req_valid_i && usr && req_i.op == CSA_OP_MFTB |-> !priv_fault_o;
    endproperty
    a_tb_path: assert property (p_tb_path)
        else $error("user time base read refused");

    property p_dcr;
        req_valid_i && (req_i.op == CSA_OP_MTDCR || req_i.op == CSA_OP_MFDCR)
            |-> dcr_valid_o == !usr && priv_fault_o == usr;
    endproperty
    a_dcr: assert property (p_dcr)
        else $error("device control privilege wrong");

    property p_msr_guard;
        req_valid_i && usr && req_i.op == CSA_OP_MTMSR
            |-> priv_fault_o ##1 msr_o == $past(msr_o);
    endproperty
    a_msr_guard: assert property (p_msr_guard)
        else $error("user machine state write not refused");

    property p_fault_req;
        priv_fault_o |-> req_valid_i;
    endproperty
    a_fault_req: assert property (p_fault_req)
        else $error("fault without request");

    property p_we_num;
        spr_we_o |-> op_mts && spr_num_o == req_i.sprn;
    endproperty
    a_we_num: assert property (p_we_num)
        else $error("special write strobe without move");
endmodule

// File: verif/tb_top.sv
/*
 * bench for csa_core: region attributes, byte order, address forming,
 * translation, then user privilege table and a mid-run reset.
 * assumes general registers are seen through count register writes.
 */
`timescale 1ns/1ps

module tb_top
    import csa_pkg::*;
;
    typedef struct packed {
        csa_op_t    op;
        logic [9:0] sprn;
        logic       flt;
    } csa_tbrow_t;

    logic          clk_sys_i, sys_rst_i, req_valid_i, load_valid_i;
    csa_req_t      req_i;
    logic [31:0]   load_data_i, alu_result_i, spr_rdata_i;
    logic [63:0]   time_base_i;
    csa_tlb_attr_t tlb_attr_i;
    logic          acc_valid_o, priv_fault_o, spr_we_o, dcr_valid_o;
    csa_access_t   acc_o;
    logic [31:0]   store_data_o, spr_wdata_o, msr_o, cond_o, wd;
    logic [9:0]    spr_num_o;
    logic          flt, we, device_control_register;
    csa_req_t      rq;
    logic [9:0]    reg_nums [5] = '{SPR_DCACH, SPR_WTHR, SPR_GUARD,
                                    SPR_UDEF, SPR_ICACH};
    int            n_fail, total_checks;
    csa_tbrow_t    rows [15] = '{
        '{CSA_OP_MTSPR, SPR_XER, 1'b0}, '{CSA_OP_MTSPR, SPR_LINK, 1'b0},
        '{CSA_OP_MTSPR, SPR_COUNT, 1'b0}, '{CSA_OP_MFSPR, SPR_GS4, 1'b0},
        '{CSA_OP_MFSPR, SPR_GS7, 1'b0}, '{CSA_OP_MTSPR, SPR_GS4, 1'b1},
        '{CSA_OP_MTSPR, SPR_WTHR, 1'b1}, '{CSA_OP_MFSPR, SPR_LEND, 1'b1},
        '{CSA_OP_MFSPR, SPR_TBLO, 1'b1}, '{CSA_OP_MTSPR, SPR_TBUP, 1'b1},
        '{CSA_OP_MFTB, TBR_LO, 1'b0}, '{CSA_OP_MFTB, TBR_UP, 1'b0},
        '{CSA_OP_MTDCR, 10'h000, 1'b1}, '{CSA_OP_MFDCR, 10'h005, 1'b1},
        '{CSA_OP_MTMSR, 10'h000, 1'b1}};

    csa_core dut (.clk_sys_i, .sys_rst_i, .req_valid_i, .req_i,
        .load_data_i, .load_valid_i, .time_base_i, .tlb_attr_i,
        .alu_result_i, .spr_rdata_i, .acc_valid_o, .acc_o, .store_data_o,
        .priv_fault_o, .spr_we_o, .spr_num_o, .spr_wdata_o, .dcr_valid_o,
        .msr_o, .cond_o);

    // 200 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic csa_req_t mk(input csa_op_t op,
        input logic [4:0] ra, rb, rt, input logic [15:0] d,
        input logic [9:0] n);
        csa_req_t r;
        r = '0;
        r.op = op;
        r.ra = ra;
        r.rb = rb;
        r.rt = rt;
        r.disp = d;
        r.sprn = n;
        return r;
    endfunction

    // drive one request at the falling edge, keep comb answers
    task automatic issue(input csa_req_t r);
        req_valid_i = 1'b1;
        req_i = r;
        #1;
        flt = priv_fault_o;
        we = spr_we_o;
        wd = spr_wdata_o;
        device_control_register = dcr_valid_o;
        @(negedge clk_sys_i);
    endtask

    task automatic idle();
        req_valid_i = 1'b0;
        @(negedge clk_sys_i);
    endtask

    task automatic set_gr(input logic [4:0] n, input logic [31:0] v);
        alu_result_i = v;
        issue(mk(CSA_OP_ALU, 5'h00, 5'h00, n, 16'h0000, 10'h000));
    endtask

    task automatic rd_gr(input logic [4:0] n, input logic [31:0] e);
        issue(mk(CSA_OP_MTSPR, 5'h00, 5'h00, n, 16'h0000, SPR_COUNT));
        chk(wd, e);
    endtask

    task automatic mem(input logic [4:0] ra, rb, rt,
        input logic [15:0] d, input logic [2:0] f);
        csa_req_t r;
        r = mk(CSA_OP_MEM, ra, rb, rt, d, 10'h000);
        {r.idx_mode, r.update, r.base_zero} = f;
        r.size = CSA_SZ_WORD;
        issue(r);
        chk(32'(acc_valid_o), 32'h1);
    endtask

    task automatic load(input logic [31:0] d);
        idle();
        load_valid_i = 1'b1;
        load_data_i = d;
        @(negedge clk_sys_i);
        load_valid_i = 1'b0;
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // cut a hang short
    initial begin
        #100us;
        n_fail++;
        print_verdict();
    end

    initial begin
        {sys_rst_i, req_valid_i, load_valid_i} = 3'b100;
        {req_i, load_data_i, alu_result_i, spr_rdata_i} = '0;
        time_base_i = 64'h0000_0001_0000_0002;
        tlb_attr_i = 6'h2C;  // w, m, g set
        repeat (10) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        chk(msr_o, 32'h0);
        chk(32'(acc_valid_o), 32'h0);
        set_gr(5'h01, 32'h1000_0100);
        set_gr(5'h02, 32'h0000_0040);
        set_gr(5'h03, 32'h8000_0001);
        set_gr(5'h04, 32'h0000_0004);
        set_gr(5'h05, 32'hFFFF_FFFB);
        set_gr(5'h07, 32'h1800_0000);
        // region 2 only little-endian, others all but region 2
        issue(mk(CSA_OP_MTSPR, 5'h00, 5'h00, 5'h04, 16'h0000, SPR_LEND));
        foreach (reg_nums[k])
            issue(mk(CSA_OP_MTSPR, 5'h00, 5'h00, 5'h05, 16'h0000,
                     reg_nums[k]));
        mem(5'h01, 5'h00, 5'h06, 16'h0000, 3'b000);
        chk(32'(acc_o.attr), 32'h09);
        load(32'h1122_3344);
        rd_gr(5'h06, 32'h1122_3344);
        mem(5'h07, 5'h00, 5'h06, 16'h0000, 3'b000);
        chk(32'(acc_o.attr), 32'h16);
        load(32'h1122_3344);
        rd_gr(5'h06, 32'h4433_2211);
        // signed halfword, big-endian region: lowest byte is the msb
        rq = mk(CSA_OP_MEM, 5'h07, 5'h00, 5'h06, 16'h0000, 10'h000);
        rq.size = CSA_SZ_HALF;
        rq.sign_ext = 1'b1;
        issue(rq);
        load(32'h0000_3480);
        rd_gr(5'h06, 32'hFFFF_8034);
        // address forming, update used back to back
        mem(5'h01, 5'h00, 5'h06, 16'hFFF0, 3'b010);
        chk(acc_o.addr, 32'h1000_00F0);
        chk(store_data_o, 32'hFFFF_8034);
        mem(5'h01, 5'h00, 5'h06, 16'h0004, 3'b000);
        chk(acc_o.addr, 32'h1000_00F4);
        mem(5'h01, 5'h00, 5'h06, 16'h7FFC, 3'b001);
        chk(acc_o.addr, 32'h0000_7FFC);
        mem(5'h02, 5'h03, 5'h06, 16'h0000, 3'b100);
        chk(acc_o.addr, 32'h8000_0041);
        mem(5'h02, 5'h03, 5'h06, 16'h0000, 3'b101);
        chk(acc_o.addr, 32'h8000_0001);
        // signed compare, then or of lt and eq into gt, then record
        rq = mk(CSA_OP_CMP, 5'h03, 5'h02, 5'h00, 16'h0000, 10'h000);
        rq.sign_ext = 1'b1;
        issue(rq);
        chk(32'(cond_o[31:28]), 32'h8);
        rq = mk(CSA_OP_CRLOG, 5'h00, 5'h00, 5'h00, 16'h0000, 10'h000);
        rq.bt = 5'd1;
        rq.ba = 5'd0;
        rq.bb = 5'd2;
        rq.crlog = CSA_CL_OR;
        issue(rq);
        chk(32'(cond_o[31:28]), 32'hC);
        alu_result_i = 32'h0000_0000;
        rq = mk(CSA_OP_ALU, 5'h00, 5'h00, 5'h0A, 16'h0000, 10'h000);
        rq.rc = 1'b1;
        issue(rq);
        chk(32'(cond_o[31:28]), 32'h2);
        // dcr number only probes privilege, data unchecked
        issue(mk(CSA_OP_MTDCR, 5'h00, 5'h00, 5'h01, 16'h0000, 10'h000));
        chk({30'h0, device_control_register, flt}, 32'h2);
        // translation on: attributes from the page entry
        set_gr(5'h08, 32'h0000_0030);
        issue(mk(CSA_OP_MTMSR, 5'h00, 5'h00, 5'h08, 16'h0000, 10'h000));
        chk(msr_o, 32'h0000_0030);
        issue(mk(CSA_OP_MFMSR, 5'h00, 5'h00, 5'h0B, 16'h0000, 10'h000));
        issue(mk(CSA_OP_MOVE, 5'h0B, 5'h00, 5'h0C, 16'h0000, 10'h000));
        rd_gr(5'h0C, 32'h0000_0030);
        mem(5'h07, 5'h00, 5'h06, 16'h0000, 3'b000);
        chk(32'(acc_o.attr), 32'h14);
        set_gr(5'h09, 32'h0000_4000);
        issue(mk(CSA_OP_MTMSR, 5'h00, 5'h00, 5'h09, 16'h0000, 10'h000));
        // user state refusals from the table
        foreach (rows[k]) begin
            issue(mk(rows[k].op, 5'h00, 5'h00, 5'h01, 16'h0000,
                     rows[k].sprn));
            chk(32'(flt), 32'(rows[k].flt));
            chk(32'(we), 32'(rows[k].op == CSA_OP_MTSPR
                             && !rows[k].flt));
        end
        idle();
        chk(msr_o, 32'h0000_4000);
        rd_gr(5'h01, 32'h0000_0001);
        sys_rst_i = 1'b1;
        repeat (10) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        chk(msr_o | cond_o, 32'h0);
        print_verdict();
    end
endmodule

bind csa_core csa_core_monitor mon (.clk_sys_i, .sys_rst_i, .req_valid_i,
    .req_i, .acc_valid_o, .priv_fault_o, .spr_we_o, .spr_num_o,
    .dcr_valid_o, .msr_o);
